// file: logic/uoc_params.svh
// Constants for the USB OTG power and interrupt control block
`ifndef UOC_PARAMS_SVH
`define UOC_PARAMS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define UOC_ADDR_OTG 4'h0
`define UOC_ADDR_PWR 4'h4
`define UOC_ADDR_IRQ 4'h8
`define UOC_ADDR_W 4

// ----------------------------------------
// Line control bit positions
// ----------------------------------------
`define UOC_B_DPPU 7
`define UOC_B_DMPU 6
`define UOC_B_DPPD 5
`define UOC_B_DMPD 4
`define UOC_B_VBON 3
`define UOC_B_OWN 2
`define UOC_B_VCHG 1
`define UOC_B_VDIS 0

// ----------------------------------------
// Power control bit positions
// ----------------------------------------
`define UOC_B_ACTP 7
`define UOC_B_GUARD 4
`define UOC_B_BUSY 3
`define UOC_B_SUSP 1
`define UOC_B_PWR 0

// ----------------------------------------
// Interrupt flag layout
// ----------------------------------------
`define UOC_B_ERR 1
`define UOC_B_TOKEN 3
`define UOC_IRQ_WC_MASK 8'hfd
`define UOC_B_RESUME 5
`define UOC_B_IDLE 4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define UOC_RST8 8'h00
`define UOC_CLK_MHZ 100
`define UOC_RESUME_NS 2500
`define UOC_IDLE_US 3000
`define UOC_RESUME_CYC ((`UOC_RESUME_NS * `UOC_CLK_MHZ) / 1000)
`define UOC_IDLE_CYC (`UOC_IDLE_US * `UOC_CLK_MHZ)
`define UOC_BUSY_CYC 8'h10
`define UOC_RESP_OK 2'b00
`define UOC_RESP_ERR 2'b10

`endif

// file: logic/uoc_pkg.sv
// Types for the USB OTG power and interrupt control block
package uoc_pkg;
   typedef enum logic [1:0] {
      UOC_OFF = 2'b00,
      UOC_ON = 2'b01,
      UOC_DRAIN = 2'b10
   } uoc_pstate_t;
endpackage

// file: logic/uoc_line_timer.sv
// Persistence timer: pulses once a level has held for a set count
module uoc_line_timer #(
   parameter int unsigned CYC = 250
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Watched level and detection pulse
   input wire logic level,
   output logic hit
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic hit_ff;
   logic nxt_hit;

   always_comb begin
      nxt_cnt = 32'h0;
      nxt_hit = 1'b0;
      if (level) begin
         if (cnt_ff < CYC) begin
            nxt_cnt = cnt_ff + 32'h1;
            nxt_hit = (cnt_ff == CYC - 1);
         end else begin
            nxt_cnt = cnt_ff;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 32'h0;
         hit_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         hit_ff <= nxt_hit;
      end
   end

   assign hit = hit_ff;
endmodule

// file: logic/uoc_ctrl.sv
// USB OTG line, power and interrupt flag control with AXI4-Lite registers
// Functional notes
// - D+ pull-up connects when line control bit 7 is one.
// - D- pull-up connects when line control bit 6 is one.
// - D+ pull-down connects when line control bit 5 is one.
// - D- pull-down connects when line control bit 4 is one.
// - Bit 2 gives software the pull controls; otherwise hardware drives them.
// - Bit 3 requests VBUS power.
// - Bit 1 charges VBUS through a pull-up resistor.
// - Bit 0 discharges VBUS through a pull-down resistor.
// - Power bit 7 reads one while activity seen but interrupt not generated.
// - Sleep guard blocks sleep while activity or notification pending.
// - Busy reads one while active or not yet ready to re-enable.
// - Suspend gates the 48 MHz clock and lowers transceiver power.
// - Power enable off holds pull, VBUS and clock outputs inactive, releases pins, stops analog.
// - Flag bits 7..2 and 0 set by hardware, write-one-clear; bit 1 read-only.
// - Bits 31..8 of each register read zero.
// - Flag bit 0 is bus reset in device mode, detach in host mode.
// - Resume flag sets after K state holds 2.5 us.
// - Idle flag sets after bus idle for 3 ms.
// - Clearing token-done flag advances the status FIFO.
`include "uoc_params.svh"
module uoc_ctrl
   import uoc_pkg::*;
#(
   parameter int unsigned IDLE_CYC = `UOC_IDLE_CYC
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [`UOC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [`UOC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Line and transceiver status from the pins
   input wire logic k_state_pin,
   input wire logic idle_state_pin,
   // Mode, one-cycle event pulses, error level and pull requests from the USB engine
   input wire logic host_mode,
   input wire logic [7:0] hw_event,
   input wire logic error_summary,
   input wire logic activity_seen,
   input wire logic hw_dplus_pullup,
   input wire logic hw_dminus_pullup,
   input wire logic hw_dplus_pulldown,
   input wire logic hw_dminus_pulldown,
   // Pad and power controls
   output logic dplus_pullup_en,
   output logic dminus_pullup_en,
   output logic dplus_pulldown_en,
   output logic dminus_pulldown_en,
   output logic vbus_power_on,
   output logic vbus_charge_en,
   output logic vbus_discharge_en,
   output logic usb_clk_gate_en,
   output logic xcvr_low_power,
   output logic analog_en,
   output logic pins_owned,
   output logic sleep_block,
   output logic stat_fifo_advance
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [7:0] otg_ff, nxt_otg;
   logic [7:0] pwr_ff, nxt_pwr;
   logic [7:0] irq_ff, nxt_irq;
   logic act_pnd_ff, nxt_act_pnd;
   logic adv_ff, nxt_adv;
   uoc_pstate_t pst_ff, nxt_pst;
   logic [7:0] drain_ff, nxt_drain;
   logic aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
   logic [`UOC_ADDR_W-1:0] awa_ff, nxt_awa;
   logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
   logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [1:0] k_sync_ff, i_sync_ff;
   logic resume_hit, idle_hit, busy, do_wr, pwr_on;
   logic [7:0] clr;

   // ----------------------------------------
   // Pin synchronisers and persistence timers
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         k_sync_ff <= 2'b00;
         i_sync_ff <= 2'b00;
      end else begin
         k_sync_ff <= {k_sync_ff[0], k_state_pin};
         i_sync_ff <= {i_sync_ff[0], idle_state_pin};
      end
   end

   uoc_line_timer #(.CYC(`UOC_RESUME_CYC)) u_resume (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(k_sync_ff[1] & pwr_on),
      .hit(resume_hit)
   );

   uoc_line_timer #(.CYC(IDLE_CYC)) u_idle (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(i_sync_ff[1] & pwr_on),
      .hit(idle_hit)
   );

   // ----------------------------------------
   // Bus slave
   // ----------------------------------------
   assign s_axi_awready = !aw_ff && !b_ff;
   assign s_axi_wready = !w_ff && !b_ff;
   assign s_axi_arready = !r_ff;
   assign do_wr = aw_ff && w_ff && !b_ff;

   always_comb begin
      nxt_aw = aw_ff;
      nxt_w = w_ff;
      nxt_awa = awa_ff;
      nxt_wd = wd_ff;
      nxt_b = b_ff;
      nxt_bresp = bresp_ff;
      nxt_r = r_ff;
      nxt_rd = rd_ff;
      nxt_rresp = rresp_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_aw = 1'b1;
         nxt_awa = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_w = 1'b1;
         nxt_wd = s_axi_wdata & {24'h0, {8{s_axi_wstrb[0]}}};
      end
      if (do_wr) begin
         nxt_aw = 1'b0;
         nxt_w = 1'b0;
         nxt_b = 1'b1;
         nxt_bresp = (awa_ff == `UOC_ADDR_OTG || awa_ff == `UOC_ADDR_PWR ||
                      awa_ff == `UOC_ADDR_IRQ) ? `UOC_RESP_OK : `UOC_RESP_ERR;
      end
      if (b_ff && s_axi_bready) begin
         nxt_b = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_r = 1'b1;
         nxt_rresp = `UOC_RESP_OK;
         case (s_axi_araddr)
            `UOC_ADDR_OTG: nxt_rd = {24'h0, otg_ff};
            `UOC_ADDR_PWR: nxt_rd = {24'h0, act_pnd_ff, 2'b00, pwr_ff[`UOC_B_GUARD], busy,
                                     1'b0, pwr_ff[`UOC_B_SUSP], pwr_ff[`UOC_B_PWR]};
            `UOC_ADDR_IRQ: nxt_rd = {24'h0, irq_ff};
            default: begin
               nxt_rd = 32'h0;
               nxt_rresp = `UOC_RESP_ERR;
            end
         endcase
      end else if (r_ff && s_axi_rready) begin
         nxt_r = 1'b0;
      end
   end

   // ----------------------------------------
   // Registers and flags
   // ----------------------------------------
   // Engine status may be invalid while disabled and busy; software must wait
   assign pwr_on = pwr_ff[`UOC_B_PWR];
   // Busy must not dip in the cycle power drops, before the drain state is entered
   assign busy = pwr_on || (pst_ff != UOC_OFF);
   assign clr = (do_wr && awa_ff == `UOC_ADDR_IRQ) ? (wd_ff[7:0] & `UOC_IRQ_WC_MASK) : 8'h00;

   always_comb begin
      logic [7:0] set;
      set = pwr_on ? (hw_event & `UOC_IRQ_WC_MASK) : 8'h00;
      set[`UOC_B_RESUME] = set[`UOC_B_RESUME] | resume_hit;
      set[`UOC_B_IDLE] = set[`UOC_B_IDLE] | idle_hit;
      nxt_otg = otg_ff;
      nxt_pwr = pwr_ff;
      if (do_wr && awa_ff == `UOC_ADDR_OTG) begin
         nxt_otg = wd_ff[7:0];
      end
      if (do_wr && awa_ff == `UOC_ADDR_PWR) begin
         nxt_pwr = wd_ff[7:0] & 8'h13;
      end
      nxt_irq = (irq_ff & ~clr) | set;
      nxt_irq[`UOC_B_ERR] = pwr_on & error_summary;
      nxt_adv = clr[`UOC_B_TOKEN] & irq_ff[`UOC_B_TOKEN];
      nxt_act_pnd = pwr_on && (activity_seen || (act_pnd_ff && !set[`UOC_B_RESUME]));
      nxt_pst = pst_ff;
      nxt_drain = drain_ff;
      case (pst_ff)
         UOC_OFF: if (pwr_on) nxt_pst = UOC_ON;
         UOC_ON: begin
            if (!pwr_on) begin
               nxt_pst = UOC_DRAIN;
               nxt_drain = `UOC_BUSY_CYC;
            end
         end
         UOC_DRAIN: begin
            nxt_drain = drain_ff - 8'h01;
            if (drain_ff == 8'h01) nxt_pst = UOC_OFF;
         end
         default: nxt_pst = UOC_OFF;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         otg_ff <= `UOC_RST8;
         pwr_ff <= `UOC_RST8;
         irq_ff <= `UOC_RST8;
         act_pnd_ff <= 1'b0;
         adv_ff <= 1'b0;
         pst_ff <= UOC_OFF;
         drain_ff <= 8'h00;
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         b_ff <= 1'b0;
         r_ff <= 1'b0;
         awa_ff <= '0;
         wd_ff <= 32'h0;
         rd_ff <= 32'h0;
         bresp_ff <= `UOC_RESP_OK;
         rresp_ff <= `UOC_RESP_OK;
      end else begin
         otg_ff <= nxt_otg;
         pwr_ff <= nxt_pwr;
         irq_ff <= nxt_irq;
         act_pnd_ff <= nxt_act_pnd;
         adv_ff <= nxt_adv;
         pst_ff <= nxt_pst;
         drain_ff <= nxt_drain;
         aw_ff <= nxt_aw;
         w_ff <= nxt_w;
         b_ff <= nxt_b;
         r_ff <= nxt_r;
         awa_ff <= nxt_awa;
         wd_ff <= nxt_wd;
         rd_ff <= nxt_rd;
         bresp_ff <= nxt_bresp;
         rresp_ff <= nxt_rresp;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_bvalid = b_ff;
   assign s_axi_bresp = bresp_ff;
   assign s_axi_rvalid = r_ff;
   assign s_axi_rdata = rd_ff;
   assign s_axi_rresp = rresp_ff;
   assign stat_fifo_advance = adv_ff;
   // Pull controls go through the power gate so a disabled module floats the lines
   assign dplus_pullup_en = pwr_on & (otg_ff[`UOC_B_OWN] ? otg_ff[`UOC_B_DPPU] : hw_dplus_pullup);
   assign dminus_pullup_en = pwr_on & (otg_ff[`UOC_B_OWN] ? otg_ff[`UOC_B_DMPU] : hw_dminus_pullup);
   assign dplus_pulldown_en = pwr_on & (otg_ff[`UOC_B_OWN] ? otg_ff[`UOC_B_DPPD] : hw_dplus_pulldown);
   assign dminus_pulldown_en = pwr_on & (otg_ff[`UOC_B_OWN] ? otg_ff[`UOC_B_DMPD] : hw_dminus_pulldown);
   assign vbus_power_on = pwr_on & otg_ff[`UOC_B_VBON];
   assign vbus_charge_en = pwr_on & otg_ff[`UOC_B_VCHG];
   assign vbus_discharge_en = pwr_on & otg_ff[`UOC_B_VDIS];
   assign usb_clk_gate_en = pwr_on & !pwr_ff[`UOC_B_SUSP];
   assign xcvr_low_power = !pwr_on | pwr_ff[`UOC_B_SUSP];
   assign analog_en = pwr_on;
   assign pins_owned = pwr_on;
   assign sleep_block = pwr_ff[`UOC_B_GUARD] & (act_pnd_ff | activity_seen | (|irq_ff));

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_clear_wr(int b);
      do_wr && awa_ff == `UOC_ADDR_IRQ && wd_ff[b];
   endsequence

   AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_wr(5) and (pwr_on && (resume_hit || hw_event[5])) |=> irq_ff[5]) else $error("set lost to clear");
   AST_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_wr(7) and !(pwr_on && hw_event[7]) |=> !irq_ff[7]) else $error("flag not cleared");
   AST_ERR_RO: assert property (@(posedge aclk) disable iff (!aresetn)
      1'b1 |=> irq_ff[1] == $past(pwr_on & error_summary)) else $error("error bit wrong");
   AST_ADV: assert property (@(posedge aclk) disable iff (!aresetn)
      s_clear_wr(3) and irq_ff[3] |=> stat_fifo_advance) else $error("no fifo advance");
   AST_PULL: assert property (@(posedge aclk) disable iff (!aresetn)
      pwr_on && otg_ff[2] |-> dplus_pullup_en == otg_ff[7]) else $error("pull-up mismatch");
   AST_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
      !pwr_on |-> !vbus_power_on && !analog_en && !dminus_pullup_en) else $error("outputs active off");
   AST_SUSP: assert property (@(posedge aclk) disable iff (!aresetn)
      pwr_ff[1] |-> !usb_clk_gate_en && xcvr_low_power) else $error("clock not gated");
   AST_BUSY: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(pwr_on) |-> busy [*8]) else $error("busy dropped early");
   AST_HI_ZERO: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
   AST_GUARD: assert property (@(posedge aclk) disable iff (!aresetn)
      !pwr_ff[4] |-> !sleep_block) else $error("sleep blocked without guard");
endmodule

// file: verif/uoc_cable_model.sv
// Cable partner model driving the K and idle line levels
module uoc_cable_model (
   // Clock
   input wire logic aclk,
   // Line state requests from the bench
   input wire logic k_req,
   input wire logic idle_req,
   // Line levels toward the block
   output logic k_state_pin,
   output logic idle_state_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      k_state_pin = 1'b0;
      idle_state_pin = 1'b0;
   end
   // A K state is never idle, so the two levels cannot both be high
   always @(posedge aclk) begin
      k_state_pin <= k_req;
      idle_state_pin <= idle_req & ~k_req;
   end
endmodule

// file: verif/uoc_ctrl_tb.sv
// Self-checking bench for the USB OTG line, power and flag control block
`include "uoc_params.svh"
module uoc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic aclk = 0;
   logic aresetn = 0;
   logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic k_state_pin, idle_state_pin, k_req = 0, idle_req = 0;
   logic host_mode = 0, error_summary = 0, activity_seen = 0;
   logic [7:0] hw_event = 0;
   logic hw_dplus_pullup = 0, hw_dminus_pullup = 0, hw_dplus_pulldown = 0, hw_dminus_pulldown = 0;
   logic dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en;
   logic vbus_power_on, vbus_charge_en, vbus_discharge_en, usb_clk_gate_en;
   logic xcvr_low_power, analog_en, pins_owned, sleep_block, stat_fifo_advance;
   int mismatches = 0, checks = 0, adv_cnt = 0;
   // Pad controls laid out as the line control register, bit 2 shown as one
   wire [7:0] obs = {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en, dminus_pulldown_en,
      vbus_power_on, 1'b1, vbus_charge_en, vbus_discharge_en};
   // ----------------------------------------
   // Instances and clock
   // ----------------------------------------
   // Idle count shortened so the idle detector fires within the run
   uoc_ctrl #(.IDLE_CYC(50)) uut (.*);
   uoc_cable_model partner (.*);
   initial begin
      forever #5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (stat_fifo_advance === 1'b1) adv_cnt <= adv_cnt + 1;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Values are sampled at the falling edge, where they equal what the next rising edge takes
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic ta, tw, tb, pa, pw;
      int n;
      pa = 1;
      pw = 1;
      tb = 0;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!tb) begin
         @(negedge aclk);
         n++;
         ta = pa && s_axi_awready === 1'b1;
         tw = pw && s_axi_wready === 1'b1;
         tb = !pa && !pw && s_axi_bvalid === 1'b1;
         rsp = s_axi_bresp;
         if (n > 40) begin
            chk("write handshake", 1, 0);
            conclude;
         end
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 0;
         if (tw) s_axi_wvalid <= 0;
         if (tb) s_axi_bready <= 0;
         pa &= !ta;
         pw &= !tw;
      end
   endtask
   task automatic rd_reg(input logic [3:0] a);
      logic ta, tr, pa;
      int n;
      pa = 1;
      tr = 0;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!tr) begin
         @(negedge aclk);
         n++;
         ta = pa && s_axi_arready === 1'b1;
         tr = !pa && s_axi_rvalid === 1'b1;
         rd = s_axi_rdata;
         rsp = s_axi_rresp;
         if (n > 40) begin
            chk("read handshake", 1, 0);
            conclude;
         end
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 0;
         if (tr) s_axi_rready <= 0;
         pa &= !ta;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd_reg(`UOC_ADDR_OTG);
      chk("line control", 0, rd);
      rd_reg(`UOC_ADDR_PWR);
      chk("power control", 0, rd);
      rd_reg(`UOC_ADDR_IRQ);
      chk("flags", 0, rd);
      rd_reg(4'hc);
      chk("unmapped read resp", `UOC_RESP_ERR, rsp);
      wr(4'hc, 8'hff);
      chk("unmapped write resp", `UOC_RESP_ERR, rsp);
      $display("test reset done");
   endtask
   task automatic t_lines;
      wr(`UOC_ADDR_PWR, 8'h01);
      for (int i = 0; i < 8; i++) begin
         if (i != 2) begin
            wr(`UOC_ADDR_OTG, 8'h04 | (8'h01 << i));
            @(negedge aclk);
            chk("line outputs", 8'h04 | (8'h01 << i), obs);
         end
      end
      rd_reg(`UOC_ADDR_OTG);
      chk("line readback", 8'h84, rd);
      // Hardware takes the pulls back once software ownership is off
      wr(`UOC_ADDR_OTG, 8'h00);
      hw_dplus_pullup <= 1;
      hw_dminus_pulldown <= 1;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      chk("hw pulls", 8'h94, obs);
      $display("test lines done");
   endtask
   task automatic t_power;
      wr(`UOC_ADDR_OTG, 8'hff);
      wr(`UOC_ADDR_PWR, 8'h03);
      @(negedge aclk);
      chk("suspend gate", 2'b01, {usb_clk_gate_en, xcvr_low_power});
      wr(`UOC_ADDR_PWR, 8'h01);
      @(negedge aclk);
      chk("resume run", 3'b101, {usb_clk_gate_en, xcvr_low_power, analog_en});
      rd_reg(`UOC_ADDR_PWR);
      chk("busy while on", 8'h09, rd);
      wr(`UOC_ADDR_PWR, 8'h00);
      @(negedge aclk);
      chk("off outputs", 8'h04, obs);
      chk("off analog", 0, analog_en);
      rd_reg(`UOC_ADDR_PWR);
      chk("busy after off", 8'h08, rd);
      // Other registers stay untouched until busy has fallen
      repeat (20) @(posedge aclk);
      rd_reg(`UOC_ADDR_PWR);
      chk("ready after off", 8'h00, rd);
      $display("test power done");
   endtask
   task automatic t_flags;
      int a0;
      a0 = adv_cnt;
      wr(`UOC_ADDR_PWR, 8'h01);
      @(posedge aclk);
      hw_event <= 8'hff;
      error_summary <= 1;
      @(posedge aclk);
      hw_event <= 8'h00;
      rd_reg(`UOC_ADDR_IRQ);
      chk("flags set", 8'hff, rd);
      wr(`UOC_ADDR_IRQ, 8'hff);
      rd_reg(`UOC_ADDR_IRQ);
      chk("flags cleared", 8'h02, rd);
      chk("fifo advance", a0 + 1, adv_cnt);
      error_summary <= 0;
      rd_reg(`UOC_ADDR_IRQ);
      chk("error follows", 8'h00, rd);
      $display("test flags done");
   endtask
   task automatic t_activity;
      wr(`UOC_ADDR_PWR, 8'h11);
      @(posedge aclk);
      activity_seen <= 1;
      @(posedge aclk);
      activity_seen <= 0;
      @(negedge aclk);
      chk("sleep blocked", 1, sleep_block);
      rd_reg(`UOC_ADDR_PWR);
      chk("pending", 8'h99, rd);
      k_req <= 1;
      repeat (300) @(posedge aclk);
      k_req <= 0;
      rd_reg(`UOC_ADDR_IRQ);
      chk("resume flag", 8'h20, rd);
      rd_reg(`UOC_ADDR_PWR);
      chk("pending gone", 8'h19, rd);
      wr(`UOC_ADDR_PWR, 8'h01);
      @(negedge aclk);
      chk("guard off", 0, sleep_block);
      wr(`UOC_ADDR_IRQ, 8'hff);
      idle_req <= 1;
      repeat (70) @(posedge aclk);
      idle_req <= 0;
      rd_reg(`UOC_ADDR_IRQ);
      chk("idle flag", 8'h10, rd);
      // Resume event lands on the very edge that applies the clear
      fork
         wr(`UOC_ADDR_IRQ, 8'h30);
         begin
            repeat (2) @(posedge aclk);
            hw_event <= 8'h20;
            @(posedge aclk);
            hw_event <= 8'h00;
         end
      join
      rd_reg(`UOC_ADDR_IRQ);
      chk("set beats clear", 8'h20, rd);
      $display("test activity done");
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      t_reset;
      t_lines;
      t_power;
      t_flags;
      t_activity;
      conclude;
   end
endmodule
